//--- hdl/tgc_pkg.sv
// constants for the gated / capture-compare timer block
// assumes a 32-bit avalon-mm slave port, byte addressed
package tgc_pkg;
    // register byte offsets
    localparam logic [4:0] TGC_CTRL_ADDR = 5'h00;
    localparam logic [4:0] TGC_COUNT_ADDR = 5'h04;
    localparam logic [4:0] TGC_RELOAD_ADDR = 5'h08;
    localparam logic [4:0] TGC_CAPTURE_ADDR = 5'h0c;
    localparam logic [4:0] TGC_STATUS_ADDR = 5'h10;
    localparam logic [4:0] TGC_MASK_ADDR = 5'h14;
    // timer_control_one field positions
    localparam int TGC_CTRL_EN_BIT = 0;
    localparam int TGC_CTRL_MODE_LSB = 1;
    localparam int TGC_CTRL_POL_BIT = 3;
    localparam int TGC_CTRL_PRE_LSB = 4;
    localparam int TGC_CTRL_OUTEN_BIT = 7;
    localparam int TGC_CTRL_ICS_LSB = 8;
    localparam int TGC_CTRL_CAPFLAG_BIT = 10;
    // mode encodings
    localparam logic [1:0] TGC_MODE_COMPARE = 2'h0;
    localparam logic [1:0] TGC_MODE_GATED = 2'h1;
    localparam logic [1:0] TGC_MODE_CAPCMP = 2'h2;
    // interrupt_cause_select encodings
    localparam logic [1:0] TGC_ICS_BOTH = 2'h0;
    localparam logic [1:0] TGC_ICS_INPUT = 2'h1;
    localparam logic [1:0] TGC_ICS_RELOAD = 2'h2;
    // status / mask bit positions
    localparam int TGC_ST_RELOAD_BIT = 0;
    localparam int TGC_ST_DEASSERT_BIT = 1;
    localparam int TGC_ST_CAPTURE_BIT = 2;
    localparam int TGC_ST_W = 3;
    // reset and restart values
    localparam logic [15:0] TGC_COUNT_RST = 16'h0000;
    localparam logic [15:0] TGC_RELOAD_RST = 16'hffff;
    localparam logic [15:0] TGC_RESTART_COUNT = 16'h0001;
    localparam logic [2:0] TGC_MASK_RST = 3'h0;
    localparam logic [2:0] TGC_PRE_RST = 3'h0;
    localparam logic [1:0] TGC_MODE_RST = 2'h0;
    localparam logic [1:0] TGC_ICS_RST = 2'h0;
endpackage : tgc_pkg

//--- hdl/tgc_prescale.sv
// prescaler: one tick every 2**sel clocks while run is high
// assumes sel is steady while run is high
`timescale 1ns/1ns
module tgc_prescale (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // control
    input wire logic run,
    input wire logic [2:0] sel,
    // tick out
    output logic tick
);
    typedef struct packed {
        logic [6:0] cnt;
    } tgc_pre_t;

    tgc_pre_t st_ff;
    tgc_pre_t nxt_st;
    logic [6:0] limit;

    assign limit = 7'((8'h01 << sel) - 8'h01);
    assign tick = run && (st_ff.cnt == limit);

    always_comb begin
        nxt_st = st_ff;
        // restart when stopped so a fresh run gets a full period
        if (!run || tick) begin
            nxt_st.cnt = 7'h00;
        end else begin
            nxt_st.cnt = st_ff.cnt + 7'h01;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : tgc_prescale

//--- hdl/tgc_sync.sv
// two flip-flop synchroniser for one level
// assumes d may change at any time relative to clk
`timescale 1ns/1ns
module tgc_sync (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // level in and out
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic meta;
        logic stable;
    } tgc_sync_t;

    tgc_sync_t st_ff;
    tgc_sync_t nxt_st;

    always_comb begin
        nxt_st.meta = d;
        nxt_st.stable = st_ff.meta;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.stable;
endmodule : tgc_sync

//--- hdl/tgc_timer.sv
// 16-bit timer: compare, gated and capture/compare modes, avalon-mm registers
// assumes timer_in is asynchronous; bus master keeps its request until waitrequest is low
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
module tgc_timer (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // timer pins
    input wire logic timer_in,
    output logic timer_out,
    output logic timer_out_oe,
    // interrupt
    output logic irq
);
    import tgc_pkg::*;

    typedef struct packed {
        logic en;
        logic [1:0] mode;
        logic pol;
        logic [2:0] pre;
        logic out_en;
        logic [1:0] ics;
        logic cap_flag;
        logic [15:0] count;
        logic [15:0] reload;
        logic [15:0] capture;
        logic [TGC_ST_W-1:0] status;
        logic [TGC_ST_W-1:0] mask;
        logic started;
        logic in_prev;
        logic out;
        logic waitreq;
        logic [31:0] rdata;
        logic irq;
    } tgc_state_t;

    tgc_state_t st_ff;
    tgc_state_t nxt_st;

    logic in_sync;
    logic tick;
    logic run;
    logic active;
    logic sel_edge;
    logic deassert_ev;
    logic at_reload;
    logic cap_ev;
    logic bus_done;
    logic wr_ctrl;
    logic wr_count;
    logic wr_reload;
    logic wr_mask;
    logic [TGC_ST_W-1:0] rd_clr;
    logic [TGC_ST_W-1:0] ev;
    logic allow_input;
    logic allow_reload;

    tgc_sync u_sync (
        .clk(core_clk),
        .reset_n(reset_n),
        .d(timer_in),
        .q(in_sync)
    );

    tgc_prescale u_pre (
        .clk(core_clk),
        .reset_n(reset_n),
        .run(run),
        .sel(st_ff.pre),
        .tick(tick)
    );

    assign active = (in_sync == st_ff.pol);
    assign sel_edge = st_ff.pol ? (in_sync && !st_ff.in_prev) : (!in_sync && st_ff.in_prev);
    // prescaler runs only while enabled and allowed by mode
    assign run = st_ff.en
        && ((st_ff.mode != TGC_MODE_GATED) || active)
        && ((st_ff.mode != TGC_MODE_CAPCMP) || st_ff.started);
    // deassertion seen only while enabled in gated mode
    assign deassert_ev = st_ff.en && (st_ff.mode == TGC_MODE_GATED)
        && (st_ff.in_prev == st_ff.pol) && (in_sync != st_ff.pol);
    assign cap_ev = st_ff.en && (st_ff.mode == TGC_MODE_CAPCMP) && st_ff.started && sel_edge;
    // capture wins over a reload match in the same cycle
    assign at_reload = tick && (st_ff.count == st_ff.reload) && !cap_ev;

    // cause select gates which events post
    assign allow_input = (st_ff.ics != TGC_ICS_RELOAD);
    assign allow_reload = (st_ff.ics != TGC_ICS_INPUT);
    always_comb begin
        ev = '0;
        ev[TGC_ST_RELOAD_BIT] = at_reload && allow_reload;
        ev[TGC_ST_DEASSERT_BIT] = deassert_ev && allow_input;
        ev[TGC_ST_CAPTURE_BIT] = cap_ev && allow_input;
    end

    assign bus_done = (avs_read || avs_write) && !st_ff.waitreq;
    assign wr_ctrl = bus_done && avs_write && (avs_address == TGC_CTRL_ADDR);
    assign wr_count = bus_done && avs_write && (avs_address == TGC_COUNT_ADDR);
    assign wr_reload = bus_done && avs_write && (avs_address == TGC_RELOAD_ADDR);
    assign wr_mask = bus_done && avs_write && (avs_address == TGC_MASK_ADDR);
    // clear only what the read returned, so a later event is not lost
    assign rd_clr = (bus_done && avs_read && (avs_address == TGC_STATUS_ADDR))
        ? st_ff.rdata[TGC_ST_W-1:0] : '0;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : merge16

    always_comb begin
        nxt_st = st_ff;
        nxt_st.in_prev = in_sync;

        // counting
        if (st_ff.en) begin
            case (st_ff.mode)
                TGC_MODE_GATED: begin
                    // reload restarts at 0001, start count only once
                    if (at_reload) begin
                        nxt_st.count = TGC_RESTART_COUNT;
                    end else if (tick) begin
                        nxt_st.count = st_ff.count + 16'h0001;
                    end
                end
                TGC_MODE_CAPCMP: begin
                    if (!st_ff.started) begin
                        // first selected edge only arms the counter
                        nxt_st.started = sel_edge;
                    end else if (cap_ev) begin
                        nxt_st.capture = st_ff.count;
                        nxt_st.count = TGC_RESTART_COUNT;
                        nxt_st.cap_flag = 1'b1;
                    end else if (at_reload) begin
                        // compare match clears the cause flag
                        nxt_st.count = TGC_RESTART_COUNT;
                        nxt_st.cap_flag = 1'b0;
                    end else if (tick) begin
                        nxt_st.count = st_ff.count + 16'h0001;
                    end
                end
                default: begin
                    // compare mode free runs on the prescaler tick
                    if (tick) begin
                        nxt_st.count = st_ff.count + 16'h0001;
                    end
                end
            endcase
        end else begin
            nxt_st.started = 1'b0;
        end

        if (at_reload && st_ff.out_en) begin
            nxt_st.out = !st_ff.out;
        end

        // sticky status, set wins over read clear
        nxt_st.status = (st_ff.status & ~rd_clr) | ev;

        // register writes
        if (wr_ctrl) begin
            if (avs_byteenable[0]) begin
                nxt_st.en = avs_writedata[TGC_CTRL_EN_BIT];
                nxt_st.mode = avs_writedata[TGC_CTRL_MODE_LSB +: 2];
                nxt_st.pol = avs_writedata[TGC_CTRL_POL_BIT];
                nxt_st.pre = avs_writedata[TGC_CTRL_PRE_LSB +: 3];
                nxt_st.out_en = avs_writedata[TGC_CTRL_OUTEN_BIT];
            end
            if (avs_byteenable[1]) begin
                nxt_st.ics = avs_writedata[TGC_CTRL_ICS_LSB +: 2];
            end
        end
        if (wr_count) begin
            nxt_st.count = merge16(st_ff.count, avs_writedata, avs_byteenable);
        end
        if (wr_reload) begin
            nxt_st.reload = merge16(st_ff.reload, avs_writedata, avs_byteenable);
        end
        if (wr_mask && avs_byteenable[0]) begin
            nxt_st.mask = avs_writedata[TGC_ST_W-1:0];
        end

        // one wait cycle per access; read data set up during it
        nxt_st.waitreq = !((avs_read || avs_write) && st_ff.waitreq);
        if (avs_read && st_ff.waitreq) begin
            nxt_st.rdata = '0;
            case (avs_address)
                TGC_CTRL_ADDR: begin
                    nxt_st.rdata[TGC_CTRL_EN_BIT] = st_ff.en;
                    nxt_st.rdata[TGC_CTRL_MODE_LSB +: 2] = st_ff.mode;
                    nxt_st.rdata[TGC_CTRL_POL_BIT] = st_ff.pol;
                    nxt_st.rdata[TGC_CTRL_PRE_LSB +: 3] = st_ff.pre;
                    nxt_st.rdata[TGC_CTRL_OUTEN_BIT] = st_ff.out_en;
                    nxt_st.rdata[TGC_CTRL_ICS_LSB +: 2] = st_ff.ics;
                    nxt_st.rdata[TGC_CTRL_CAPFLAG_BIT] = st_ff.cap_flag;
                end
                TGC_COUNT_ADDR: begin
                    nxt_st.rdata[15:0] = st_ff.count;
                end
                TGC_RELOAD_ADDR: begin
                    nxt_st.rdata[15:0] = st_ff.reload;
                end
                TGC_CAPTURE_ADDR: begin
                    nxt_st.rdata[15:0] = st_ff.capture;
                end
                TGC_STATUS_ADDR: begin
                    nxt_st.rdata[TGC_ST_W-1:0] = st_ff.status;
                end
                TGC_MASK_ADDR: begin
                    nxt_st.rdata[TGC_ST_W-1:0] = st_ff.mask;
                end
                default: begin
                    nxt_st.rdata = '0;
                end
            endcase
        end

        // next mask too, so a mask write never leaves irq a cycle behind
        nxt_st.irq = |(nxt_st.status & nxt_st.mask);
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
            st_ff.mode <= TGC_MODE_RST;
            st_ff.pre <= TGC_PRE_RST;
            st_ff.ics <= TGC_ICS_RST;
            st_ff.count <= TGC_COUNT_RST;
            st_ff.reload <= TGC_RELOAD_RST;
            st_ff.mask <= TGC_MASK_RST;
            st_ff.waitreq <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avs_readdata = st_ff.rdata;
    assign avs_waitrequest = st_ff.waitreq;
    assign timer_out = st_ff.out;
    assign timer_out_oe = st_ff.out_en;
    assign irq = st_ff.irq;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_capture;
        cap_ev && !wr_count;
    endsequence
    sequence s_restart_flagged;
        (st_ff.count == TGC_RESTART_COUNT) && st_ff.cap_flag;
    endsequence

    property p_compare_step;
        (st_ff.en && st_ff.mode == TGC_MODE_COMPARE && tick && !wr_count && !wr_ctrl)
            |=> st_ff.count == 16'($past(st_ff.count) + 16'h0001);
    endproperty
    a_compare_step: assert property (p_compare_step) else $error("compare count did not step");

    property p_gated_hold;
        (st_ff.en && st_ff.mode == TGC_MODE_GATED && !active && !wr_count) |=> $stable(st_ff.count);
    endproperty
    a_gated_hold: assert property (p_gated_hold) else $error("gated count moved while inactive");

    property p_deassert_irq;
        (deassert_ev && st_ff.ics != TGC_ICS_RELOAD) |=> st_ff.status[TGC_ST_DEASSERT_BIT];
    endproperty
    a_deassert_irq: assert property (p_deassert_irq) else $error("deassert status not set");

    property p_gated_reload;
        (at_reload && st_ff.mode == TGC_MODE_GATED && !wr_count && st_ff.ics != TGC_ICS_INPUT)
            |=> (st_ff.count == TGC_RESTART_COUNT) && st_ff.status[TGC_ST_RELOAD_BIT];
    endproperty
    a_gated_reload: assert property (p_gated_reload) else $error("gated reload wrong");

    property p_out_toggle;
        (at_reload && st_ff.out_en) |=> timer_out != $past(timer_out);
    endproperty
    a_out_toggle: assert property (p_out_toggle) else $error("timer output did not toggle");

    property p_second_pass;
        (at_reload && st_ff.mode == TGC_MODE_GATED && !wr_count) ##1 (tick && !wr_count && !at_reload)
            |=> st_ff.count == 16'h0002;
    endproperty
    a_second_pass: assert property (p_second_pass) else $error("second pass not from 0001");

    property p_cause_sel;
        (st_ff.ics == TGC_ICS_RELOAD && !st_ff.status[TGC_ST_DEASSERT_BIT]
            && !st_ff.status[TGC_ST_CAPTURE_BIT])
            |=> !st_ff.status[TGC_ST_DEASSERT_BIT] && !st_ff.status[TGC_ST_CAPTURE_BIT];
    endproperty
    a_cause_sel: assert property (p_cause_sel) else $error("input event posted while masked by select");

    property p_wait_edge;
        (st_ff.en && st_ff.mode == TGC_MODE_CAPCMP && !st_ff.started && !wr_count) |=> $stable(st_ff.count);
    endproperty
    a_wait_edge: assert property (p_wait_edge) else $error("counted before first edge");

    property p_capture_value;
        s_capture |=> st_ff.capture == $past(st_ff.count);
    endproperty
    a_capture_value: assert property (p_capture_value) else $error("capture value wrong");

    property p_capture_restart;
        s_capture |=> s_restart_flagged;
    endproperty
    a_capture_restart: assert property (p_capture_restart) else $error("capture restart wrong");

    property p_compare_clear;
        (at_reload && st_ff.mode == TGC_MODE_CAPCMP && st_ff.started) |=> !st_ff.cap_flag;
    endproperty
    a_compare_clear: assert property (p_compare_clear) else $error("cause flag not cleared");

    property p_input_only;
        (st_ff.ics == TGC_ICS_INPUT && !st_ff.status[TGC_ST_RELOAD_BIT])
            |=> !st_ff.status[TGC_ST_RELOAD_BIT];
    endproperty
    a_input_only: assert property (p_input_only) else $error("reload posted while masked by select");

    property p_disabled_hold;
        (!st_ff.en && !wr_count) |=> $stable(st_ff.count);
    endproperty
    a_disabled_hold: assert property (p_disabled_hold) else $error("count moved while disabled");

    property p_irq_level;
        (|(st_ff.status & st_ff.mask)) |-> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq low with unmasked status");
endmodule : tgc_timer

//--- tb/tgc_pin_model.sv
// timer input pin source standing in for the external signal
// assumes the bench sets want and lag; the pin is push-pull, never released
`timescale 1ns/1ns
module tgc_pin_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // requested level and its delay in cycles
    input wire logic want,
    input wire logic [3:0] lag,
    // pin
    output logic timer_in
);
    logic [3:0] wait_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_in <= 1'b0;
            wait_ff <= 4'h0;
        end else if (want == timer_in) begin
            wait_ff <= 4'h0;
        end else if (wait_ff >= lag) begin
            // slow source: edge lands lag cycles late
            timer_in <= want;
            wait_ff <= 4'h0;
        end else begin
            wait_ff <= wait_ff + 4'h1;
        end
    end
endmodule : tgc_pin_model

//--- tb/tgc_timer_tb.sv
// self-checking bench for the gated / capture-compare timer
// assumes tgc_pkg, tgc_timer and tgc_pin_model are compiled first
`timescale 1ns/1ns
module tgc_timer_tb;
    import tgc_pkg::*;
    logic core_clk;
    logic reset_n;
    logic [4:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic timer_in;
    logic timer_out;
    logic timer_out_oe;
    logic irq;
    logic want;
    logic [3:0] lag;
    logic exp_out;
    logic pol;
    logic [1:0] ics;
    logic [31:0] est;
    logic [31:0] rd;
    logic [31:0] c;
    int n_errors;
    int samples_checked;

    tgc_timer uut (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .timer_in(timer_in),
        .timer_out(timer_out), .timer_out_oe(timer_out_oe), .irq(irq));
    tgc_pin_model pin_src (.clk(core_clk), .reset_n(reset_n), .want(want), .lag(lag), .timer_in(timer_in));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic conclude();
        $display("checks made %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // request held until waitrequest is sampled low; bounded wait
    task automatic bus(input logic wr_n_rd, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr_n_rd;
        avs_read <= !wr_n_rd;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            n_errors++;
            $display("wrong value waitrequest: expected 0, seen %b", avs_waitrequest);
            conclude();
        end
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask : wr

    task automatic rdc(input string what, input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, rd);
        chk(what, exp, rd);
    endtask : rdc

    task automatic ticks(input int n);
        repeat (n) @(posedge core_clk);
    endtask : ticks

    function automatic logic [31:0] ctl(input logic en, input logic [1:0] md, input logic p, input logic [2:0] pre,
        input logic [1:0] cs);
        ctl = 32'h0;
        ctl[TGC_CTRL_EN_BIT] = en;
        ctl[TGC_CTRL_MODE_LSB +: 2] = md;
        ctl[TGC_CTRL_POL_BIT] = p;
        ctl[TGC_CTRL_PRE_LSB +: 3] = pre;
        ctl[TGC_CTRL_OUTEN_BIT] = 1'b1;
        ctl[TGC_CTRL_ICS_LSB +: 2] = cs;
    endfunction : ctl

    initial begin
        reset_n = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h3;
        want = 1'b0;
        lag = 4'h0;
        exp_out = 1'b0;
        n_errors = 0;
        samples_checked = 0;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        rdc("ctrl reset", TGC_CTRL_ADDR, 32'h0);
        rdc("count reset", TGC_COUNT_ADDR, {16'h0, TGC_COUNT_RST});
        rdc("reload reset", TGC_RELOAD_ADDR, {16'h0, TGC_RELOAD_RST});
        rdc("capture reset", TGC_CAPTURE_ADDR, 32'h0);
        rdc("status reset", TGC_STATUS_ADDR, 32'h0);
        rdc("mask reset", TGC_MASK_ADDR, {29'h0, TGC_MASK_RST});
        wr(5'h18, 32'h0000_ffff);
        rdc("unmapped", 5'h18, 32'h0);
        wr(TGC_CAPTURE_ADDR, 32'h0000_1234);
        rdc("capture read only", TGC_CAPTURE_ADDR, 32'h0);
        avs_byteenable <= 4'h1;
        wr(TGC_RELOAD_ADDR, 32'h0000_12ab);
        avs_byteenable <= 4'h3;
        rdc("reload low lane only", TGC_RELOAD_ADDR, {16'h0, TGC_RELOAD_RST[15:8], 8'hab});
        $display("test registers done");

        wr(TGC_CTRL_ADDR, ctl(1'b0, TGC_MODE_COMPARE, 1'b1, 3'h3, TGC_ICS_BOTH));
        wr(TGC_COUNT_ADDR, 32'h0000_1234);
        ticks(20);
        rdc("count while disabled", TGC_COUNT_ADDR, 32'h0000_1234);
        wr(TGC_COUNT_ADDR, 32'h0);
        wr(TGC_RELOAD_ADDR, 32'h0000_0004);
        wr(TGC_MASK_ADDR, 32'h7);
        wr(TGC_CTRL_ADDR, ctl(1'b1, TGC_MODE_COMPARE, 1'b1, 3'h3, TGC_ICS_BOTH));
        ticks(12);
        rdc("status before match", TGC_STATUS_ADDR, 32'h0);
        ticks(40);
        exp_out = ~exp_out;
        chk("irq on match", 32'h1, {31'h0, irq});
        chk("output pin", {30'h0, 1'b1, exp_out}, {30'h0, timer_out_oe, timer_out});
        rdc("status match", TGC_STATUS_ADDR, 32'h1);
        ticks(3);
        chk("irq after clear", 32'h0, {31'h0, irq});
        $display("test compare done");

        for (int i = 0; i < 3; i++) begin
            pol = (i != 1);
            ics = (i == 0) ? TGC_ICS_BOTH : (i == 1) ? TGC_ICS_INPUT : TGC_ICS_RELOAD;
            est = (i == 0) ? 32'h3 : (i == 1) ? 32'h2 : 32'h1;
            wr(TGC_CTRL_ADDR, ctl(1'b0, TGC_MODE_GATED, pol, 3'h0, ics));
            want <= ~pol;
            lag <= i[3:0];
            wr(TGC_COUNT_ADDR, 32'h0000_0100);
            wr(TGC_RELOAD_ADDR, 32'h0000_0105);
            wr(TGC_CTRL_ADDR, ctl(1'b1, TGC_MODE_GATED, pol, 3'h0, ics));
            rdc("gated status idle", TGC_STATUS_ADDR, 32'h0);
            ticks(20);
            rdc("gated count idle", TGC_COUNT_ADDR, 32'h0000_0100);
            want <= pol;
            ticks(30);
            want <= ~pol;
            ticks(20);
            exp_out = ~exp_out;
            chk("gated irq", 32'h1, {31'h0, irq});
            chk("gated output pin", {31'h0, exp_out}, {31'h0, timer_out});
            chk("input against polarity", {31'h0, ~pol}, {31'h0, timer_in});
            rdc("gated status", TGC_STATUS_ADDR, est);
            bus(1'b0, TGC_COUNT_ADDR, 32'h0, c);
            chk("count high byte after restart", 32'h0, {24'h0, c[15:8]});
            ticks(10);
            rdc("count held while deasserted", TGC_COUNT_ADDR, c);
        end
        $display("test gated done");

        lag <= 4'h5;
        want <= 1'b0;
        wr(TGC_CTRL_ADDR, ctl(1'b0, TGC_MODE_CAPCMP, 1'b1, 3'h0, TGC_ICS_BOTH));
        wr(TGC_COUNT_ADDR, 32'h0000_0001);
        wr(TGC_RELOAD_ADDR, 32'h0000_ffff);
        wr(TGC_CTRL_ADDR, ctl(1'b1, TGC_MODE_CAPCMP, 1'b1, 3'h0, TGC_ICS_BOTH));
        ticks(20);
        rdc("count before first edge", TGC_COUNT_ADDR, 32'h0000_0001);
        want <= 1'b1;
        ticks(40);
        want <= 1'b0;
        ticks(20);
        want <= 1'b1;
        ticks(20);
        bus(1'b0, TGC_CAPTURE_ADDR, 32'h0, c);
        samples_checked++;
        // edges 60 cycles apart, counting from 0001 at the arming edge
        if ((c >= 32'h3b && c <= 32'h3f) !== 1'b1) begin
            n_errors++;
            $display("wrong value capture: expected 003b to 003f, seen %h", c);
        end
        rdc("status capture", TGC_STATUS_ADDR, 32'h4);
        rdc("capture flag set", TGC_CTRL_ADDR,
            ctl(1'b1, TGC_MODE_CAPCMP, 1'b1, 3'h0, TGC_ICS_BOTH) | (32'h1 << TGC_CTRL_CAPFLAG_BIT));
        bus(1'b0, TGC_COUNT_ADDR, 32'h0, c);
        chk("count after capture", 32'h0, {22'h0, c[15:6]});
        wr(TGC_RELOAD_ADDR, 32'h0000_0040);
        ticks(80);
        rdc("status compare", TGC_STATUS_ADDR, 32'h1);
        rdc("capture flag clear", TGC_CTRL_ADDR, ctl(1'b1, TGC_MODE_CAPCMP, 1'b1, 3'h0, TGC_ICS_BOTH));
        wr(TGC_CTRL_ADDR, ctl(1'b1, TGC_MODE_CAPCMP, 1'b1, 3'h0, TGC_ICS_RELOAD));
        bus(1'b0, TGC_STATUS_ADDR, 32'h0, c);
        want <= 1'b0;
        ticks(20);
        want <= 1'b1;
        ticks(15);
        bus(1'b0, TGC_STATUS_ADDR, 32'h0, c);
        chk("capture event suppressed", 32'h0, {31'h0, c[TGC_ST_CAPTURE_BIT]});
        $display("test capture done");
        conclude();
    end
endmodule : tgc_timer_tb
